// ---- rsc_map.vh ----
// register offsets, field positions, reset values and timing constants of the rail sequencing config
`ifndef RSC_MAP_VH
`define RSC_MAP_VH
`define RSC_OFF_USER 8'hD1
`define RSC_OFF_RAIL 8'hD3
`define RSC_OFF_PGD 8'hD4
`define RSC_OFF_TUNE 8'hDF
`define RSC_OFF_ORDER 8'hE0
`define RSC_RST_USER 8'h00
`define RSC_RST_RAIL 8'h00
`define RSC_RST_PGD 16'hCA00
`define RSC_RST_TUNE 32'h015A_0100
`define RSC_RST_ORDER 16'h0000
`define RSC_USER_MASK 8'h1F
`define RSC_RAIL_MASK 8'h1F
`define RSC_TUNE_MASK 32'h01FF_FFFF
`define RSC_ORDER_MASK 16'h9F9F
`define RSC_USER_EXTERNAL_TEMP_SENSE 0
`define RSC_USER_PUSHPULL 1
`define RSC_USER_MINEN 2
`define RSC_USER_MINSEL_HI 4
`define RSC_USER_MINSEL_LO 3
`define RSC_TUNE_EN 24
`define RSC_ORD_PRE_EN 15
`define RSC_ORD_PRE_HI 12
`define RSC_ORD_PRE_LO 8
`define RSC_ORD_SEQ_EN 7
`define RSC_ORD_SEQ_HI 4
`define RSC_ORD_SEQ_LO 0
// minimum duty in units of 1/256 of a period: 0.39, 0.78, 1.17, 1.56 percent
`define RSC_MIN_DUTY_UNIT 8'h01
// delay tick: 125 ns in ns, clock period in ns
`define RSC_TICK_NS 125
`define RSC_CLK_NS 50
`endif

// ---- rsc_lin16_to_ticks.v ----
// converts a linear_float16 delay in ms into a count of 125 ns ticks
`timescale 1ns/1ps
module rsc_lin16_to_ticks #(
  parameter CW = 23
) (
  input wire [15:0] lin_val, // exponent 15:11, mantissa 10:0
  output reg [CW-1:0] ticks // delay in 125 ns steps, saturated
);
  // one ms is 8000 ticks; value ms = mant * 2^exp
  reg signed [4:0] expo;
  reg signed [10:0] mant;
  reg [47:0] prod;
  reg [47:0] shifted;
  always @* begin
    expo = lin_val[15:11];
    mant = lin_val[10:0];
    prod = 48'h0000_0000_0000;
    shifted = 48'h0000_0000_0000;
    ticks = {CW{1'b0}};
    if (!mant[10]) begin // negative delays clamp to zero
      prod = {37'd0, mant} * 48'd8000;
      if (expo[4])
        shifted = prod >> (~expo + 5'd1);
      else
        shifted = prod << expo;
      if (shifted > {{(48-CW){1'b0}}, {CW{1'b1}}})
        ticks = {CW{1'b1}};
      else
        ticks = shifted[CW-1:0];
    end
  end
endmodule // rsc_lin16_to_ticks

// ---- rsc_top.v ----
// rail sequencing configuration registers and the sequencing, power-ok and ramp logic they steer
`timescale 1ns/1ps
`include "rsc_map.vh"
// Behaviour
// - written user feature values replace the strap-derived defaults
// - ramp minimum duty picked by bits 4:3, 0.39 to 1.56 percent
// - minimum duty enforced only while bit 2 is set
// - power-ok pin open drain on bit 1 low, push-pull on high
// - external temperature sensing runs only while bit 0 is set
// - rail identifier is the five-bit field 4:0, bits 7:5 reserved
// - power-ok asserts after programmed delay, 125 ns steps up to 8388607 ticks, about 1048 ms
// - delay held as linear_float16, reset code CA00 meaning 4 ms
// - 32-bit tuning word: enable bit 24, residual 23:16, gain 15:0
// - with prequel on, output enables on enable and prequel power-ok event
// - with sequel on, output turns off after sequel power-down event
// - bit 15 prequel enable, bits 12:8 prequel rail identifier
// - bit 7 sequel enable, bits 4:0 sequel rail identifier
// - sequencing register overrides strap order, resets to 0000h
module rsc_top #(
  parameter TCW = 23 // width of the power-ok tick counter
) (
  input wire CLK, // 20 MHz clock
  input wire SRST, // synchronous reset, active high
  input wire [7:0] CMD_CODE, // command code of the access
  input wire [31:0] WR_DATA, // write data, low bytes used per width
  input wire WR_EN, // one-cycle write strobe
  input wire RD_EN, // one-cycle read strobe
  output reg [31:0] RD_DATA, // read data, zero-extended
  output reg RD_VALID, // read answer strobe
  output reg CMD_ERR, // unmapped command code pulse
  input wire STRAP_LOAD, // strap values valid pulse
  input wire [7:0] STRAP_USER, // strap-derived user feature value
  input wire [15:0] STRAP_ORDER, // strap-derived sequencing value
  input wire ENABLE_REQ, // enable condition from pin/operation policy
  input wire VOUT_ABOVE_PG, // output above power-ok threshold, async
  input wire BUS_EVT_VALID, // coordination bus event strobe
  input wire [4:0] BUS_EVT_RAIL, // sender rail identifier
  input wire BUS_EVT_PG, // event is power-ok
  input wire BUS_EVT_DOWN, // event is power-down
  output reg OUT_ON, // converter output enable
  output reg PG_O, // power-ok pin output level
  output reg PG_OE, // power-ok pin output enable
  output reg [7:0] MIN_DUTY, // ramp minimum duty, 1/256 units
  output reg EXTERNAL_TEMP_SENSE_EN, // external temperature sensing on
  output reg [4:0] RAIL_ID, // own rail identifier
  output reg TUNE_EN, // loop response tuning on
  output reg [7:0] TUNE_RESID, // tuning residual setting
  output reg [15:0] TUNE_GAIN // tuning gain setting
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] user_feature_config;
  reg [7:0] rail_identifier;
  reg [15:0] power_ok_delay;
  reg [31:0] loop_tuning_config;
  reg [15:0] rail_order_links;
  reg user_written; // software value sticks over later strap loads
  reg order_written;

  always @(posedge CLK) begin
    if (SRST) begin
      user_feature_config <= `RSC_RST_USER;
      rail_identifier <= `RSC_RST_RAIL;
      power_ok_delay <= `RSC_RST_PGD;
      loop_tuning_config <= `RSC_RST_TUNE;
      rail_order_links <= `RSC_RST_ORDER;
      user_written <= 1'b0;
      order_written <= 1'b0;
    end else begin
      if (STRAP_LOAD && !user_written)
        user_feature_config <= STRAP_USER & `RSC_USER_MASK;
      if (STRAP_LOAD && !order_written)
        rail_order_links <= STRAP_ORDER & `RSC_ORDER_MASK;
      if (WR_EN) begin
        case (CMD_CODE)
          `RSC_OFF_USER: begin
            user_feature_config <= WR_DATA[7:0] & `RSC_USER_MASK;
            user_written <= 1'b1;
          end
          `RSC_OFF_RAIL: rail_identifier <= WR_DATA[7:0] & `RSC_RAIL_MASK;
          `RSC_OFF_PGD: power_ok_delay <= WR_DATA[15:0];
          `RSC_OFF_TUNE: loop_tuning_config <= WR_DATA & `RSC_TUNE_MASK;
          `RSC_OFF_ORDER: begin
            rail_order_links <= WR_DATA[15:0] & `RSC_ORDER_MASK;
            order_written <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  reg [31:0] next_rd;
  reg next_hit;
  always @* begin
    next_rd = 32'h0000_0000;
    next_hit = 1'b1;
    case (CMD_CODE)
      `RSC_OFF_USER: next_rd = {24'h00_0000, user_feature_config};
      `RSC_OFF_RAIL: next_rd = {24'h00_0000, rail_identifier};
      `RSC_OFF_PGD: next_rd = {16'h0000, power_ok_delay};
      `RSC_OFF_TUNE: next_rd = loop_tuning_config;
      `RSC_OFF_ORDER: next_rd = {16'h0000, rail_order_links};
      default: next_hit = 1'b0;
    endcase
  end

  always @(posedge CLK) begin
    if (SRST) begin
      RD_DATA <= 32'h0000_0000;
      RD_VALID <= 1'b0;
      CMD_ERR <= 1'b0;
    end else begin
      RD_VALID <= RD_EN & next_hit;
      CMD_ERR <= (RD_EN | WR_EN) & ~next_hit;
      if (RD_EN)
        RD_DATA <= next_rd;
    end
  end

  // ----------------------------------------
  // static configuration outputs
  // ----------------------------------------
  wire [1:0] min_sel = user_feature_config[`RSC_USER_MINSEL_HI:`RSC_USER_MINSEL_LO];
  always @(posedge CLK) begin
    if (SRST) begin
      MIN_DUTY <= 8'h00;
      EXTERNAL_TEMP_SENSE_EN <= 1'b0;
      RAIL_ID <= 5'h00;
      TUNE_EN <= 1'b0;
      TUNE_RESID <= 8'h00;
      TUNE_GAIN <= 16'h0000;
    end else begin
      // 0.39 percent per step is one 1/256 unit, so code+1 units
      if (user_feature_config[`RSC_USER_MINEN])
        MIN_DUTY <= ({6'h00, min_sel} + 8'h01) * `RSC_MIN_DUTY_UNIT;
      else
        MIN_DUTY <= 8'h00;
      EXTERNAL_TEMP_SENSE_EN <= user_feature_config[`RSC_USER_EXTERNAL_TEMP_SENSE];
      RAIL_ID <= rail_identifier[4:0];
      TUNE_EN <= loop_tuning_config[`RSC_TUNE_EN];
      TUNE_RESID <= loop_tuning_config[23:16];
      TUNE_GAIN <= loop_tuning_config[15:0];
    end
  end

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  wire pre_en = rail_order_links[`RSC_ORD_PRE_EN];
  wire [4:0] pre_id = rail_order_links[`RSC_ORD_PRE_HI:`RSC_ORD_PRE_LO];
  wire seq_en = rail_order_links[`RSC_ORD_SEQ_EN];
  wire [4:0] seq_id = rail_order_links[`RSC_ORD_SEQ_HI:`RSC_ORD_SEQ_LO];
  reg pre_seen; // prequel reported power-ok
  reg seq_down; // sequel reported power-down
  wire pre_evt = BUS_EVT_VALID & BUS_EVT_PG & (BUS_EVT_RAIL == pre_id);
  wire seq_evt = BUS_EVT_VALID & BUS_EVT_DOWN & (BUS_EVT_RAIL == seq_id);

  always @(posedge CLK) begin
    if (SRST) begin
      pre_seen <= 1'b0;
      seq_down <= 1'b0;
      OUT_ON <= 1'b0;
    end else begin
      // set wins over clear when an event lands with the enable drop
      if (pre_evt)
        pre_seen <= 1'b1;
      else if (!ENABLE_REQ && !OUT_ON)
        pre_seen <= 1'b0;
      if (seq_evt)
        seq_down <= 1'b1;
      else if (!OUT_ON)
        seq_down <= 1'b0;
      if (!ENABLE_REQ)
        OUT_ON <= 1'b0;
      else if (seq_en && (seq_down || seq_evt))
        OUT_ON <= 1'b0;
      else if (!OUT_ON && (!pre_en || pre_seen || pre_evt))
        OUT_ON <= 1'b1;
    end
  end

  // ----------------------------------------
  // power-ok delay
  // ----------------------------------------
  reg vout_meta;
  reg vout_sync;
  always @(posedge CLK) begin
    if (SRST) begin
      vout_meta <= 1'b0;
      vout_sync <= 1'b0;
    end else begin
      vout_meta <= VOUT_ABOVE_PG;
      vout_sync <= vout_meta;
    end
  end

  wire [TCW-1:0] delay_ticks;
  rsc_lin16_to_ticks #(
    .CW(TCW)
  ) u_conv (
    .lin_val(power_ok_delay),
    .ticks(delay_ticks)
  );

  // one 125 ns tick spans 2.5 clocks; a fractional accumulator keeps the average exact
  reg [2:0] frac;
  reg [TCW-1:0] tick_cnt;
  wire tick = (frac + 3'd2 >= 3'd5);
  always @(posedge CLK) begin
    if (SRST || !vout_sync || !OUT_ON) begin
      frac <= 3'd0;
      tick_cnt <= {TCW{1'b0}};
    end else begin
      frac <= tick ? frac + 3'd2 - 3'd5 : frac + 3'd2;
      if (tick && tick_cnt < delay_ticks)
        tick_cnt <= tick_cnt + {{(TCW-1){1'b0}}, 1'b1};
    end
  end

  wire pg_good = vout_sync & OUT_ON & (tick_cnt >= delay_ticks);
  always @(posedge CLK) begin
    if (SRST) begin
      PG_O <= 1'b0;
      PG_OE <= 1'b1;
    end else begin
      PG_O <= pg_good;
      // open drain only pulls low; push-pull drives both levels
      if (user_feature_config[`RSC_USER_PUSHPULL])
        PG_OE <= 1'b1;
      else
        PG_OE <= ~pg_good;
    end
  end
endmodule // rsc_top

// ---- rsc_top_checker.sv ----
// concurrent checks on the ports of the rail sequencing config block
`timescale 1ns/1ps
`include "rsc_map.vh"
module rsc_top_checker (
  input wire CLK, // clock
  input wire SRST, // reset
  input wire [7:0] CMD_CODE, // code
  input wire [31:0] WR_DATA, // write data
  input wire WR_EN, // write
  input wire RD_EN, // read
  input wire RD_VALID, // answer
  input wire CMD_ERR, // unmapped
  input wire ENABLE_REQ, // enable
  input wire VOUT_ABOVE_PG, // vout ok
  input wire OUT_ON, // output on
  input wire PG_O, // power-ok
  input wire [7:0] MIN_DUTY, // duty
  input wire EXTERNAL_TEMP_SENSE_EN, // temp sense
  input wire [4:0] RAIL_ID, // rail
  input wire TUNE_EN, // tune on
  input wire [7:0] TUNE_RESID, // residual
  input wire [15:0] TUNE_GAIN // gain
);
  // ----------
  // properties
  // ----------
  wire mapped = CMD_CODE == `RSC_OFF_USER || CMD_CODE == `RSC_OFF_RAIL
    || CMD_CODE == `RSC_OFF_PGD || CMD_CODE == `RSC_OFF_TUNE || CMD_CODE == `RSC_OFF_ORDER;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // a quiet cycle after the write, so the field output has settled one edge later
  sequence s_wr(a);
    WR_EN && CMD_CODE == a ##1 !(WR_EN && CMD_CODE == a);
  endsequence
  a_user_fields: assert property (s_wr(`RSC_OFF_USER) |=>
    MIN_DUTY == ($past(WR_DATA[2], 2) ? {6'h00, $past(WR_DATA[4:3], 2)} + 8'h01 : 8'h00)
    && EXTERNAL_TEMP_SENSE_EN == $past(WR_DATA[0], 2)) else $error("user fields wrong");
  a_rail_field: assert property (s_wr(`RSC_OFF_RAIL) |=>
    RAIL_ID == $past(WR_DATA[4:0], 2)) else $error("rail id wrong");
  a_tune_fields: assert property (s_wr(`RSC_OFF_TUNE) |=> TUNE_EN == $past(WR_DATA[24], 2)
    && TUNE_RESID == $past(WR_DATA[23:16], 2) && TUNE_GAIN == $past(WR_DATA[15:0], 2))
    else $error("tuning fields wrong");
  a_tune_reset: assert property ($fell(SRST) |=> TUNE_EN && TUNE_RESID == 8'h5A
    && TUNE_GAIN == 16'h0100 && MIN_DUTY == 8'h00) else $error("reset fields wrong");
  a_read_answer: assert property (RD_EN && mapped |=> RD_VALID && !CMD_ERR)
    else $error("read not answered");
  a_unmapped_err: assert property ((RD_EN || WR_EN) && !mapped |=> CMD_ERR && !RD_VALID)
    else $error("unmapped not flagged");
  a_read_cause: assert property (RD_VALID |-> $past(RD_EN) && $past(mapped))
    else $error("stray read answer");
  a_out_cause: assert property ($rose(OUT_ON) |-> $past(ENABLE_REQ))
    else $error("output on without enable");
  a_pg_cause: assert property ($rose(PG_O) |-> $past(VOUT_ABOVE_PG, 2) && $past(OUT_ON))
    else $error("power-ok without vout");
endmodule // rsc_top_checker
bind rsc_top rsc_top_checker u_chk (.CLK, .SRST, .CMD_CODE, .WR_DATA, .WR_EN, .RD_EN,
  .RD_VALID, .CMD_ERR, .ENABLE_REQ, .VOUT_ABOVE_PG, .OUT_ON, .PG_O, .MIN_DUTY, .EXTERNAL_TEMP_SENSE_EN,
  .RAIL_ID, .TUNE_EN, .TUNE_RESID, .TUNE_GAIN);

// ---- rsc_peer_model.sv ----
// peer rail that puts events on the coordination bus
`timescale 1ns/1ps
module rsc_peer_model (
  input wire clk, // clock
  input wire send, // emit one event
  input wire [4:0] rail, // sender rail
  input wire down, // power-down, else power-ok
  output reg evt_valid, // event strobe
  output reg [4:0] evt_rail, // rail lines
  output reg evt_pg, // power-ok type
  output reg evt_down // power-down type
);
  initial begin
    evt_valid = 1'b0;
    evt_rail = 5'h00;
    evt_pg = 1'b0;
    evt_down = 1'b1;
  end
  // idle lines wander so stale values cannot be leaned on
  always @(posedge clk) begin
    evt_valid <= send;
    evt_rail <= send ? rail : ~evt_rail;
    evt_pg <= send ? !down : ~evt_pg;
    evt_down <= send ? down : ~evt_down;
  end
endmodule // rsc_peer_model

// ---- rail_sequencing_config_tb.sv ----
// self-checking bench of the rail sequencing config block
`timescale 1ns/1ps
`include "rsc_map.vh"
module rail_sequencing_config_tb;
  reg CLK, SRST, WR_EN, RD_EN, STRAP_LOAD, ENABLE_REQ, VOUT_ABOVE_PG, send, down;
  reg [7:0] CMD_CODE, STRAP_USER;
  reg [31:0] WR_DATA, d, x;
  reg [15:0] STRAP_ORDER;
  reg [4:0] rail;
  reg [1:0] f;
  reg [31:0] ex [0:4];
  reg [7:0] ofs [0:4];
  wire [31:0] RD_DATA;
  wire RD_VALID, CMD_ERR, BUS_EVT_VALID, BUS_EVT_PG, BUS_EVT_DOWN, OUT_ON, PG_O, PG_OE;
  wire EXTERNAL_TEMP_SENSE_EN, TUNE_EN;
  wire [4:0] BUS_EVT_RAIL, RAIL_ID;
  wire [7:0] MIN_DUTY, TUNE_RESID;
  wire [15:0] TUNE_GAIN;
  integer n_fail, comparisons, cyc, i, j, n, seed;
  rsc_top #(.TCW(23)) u_dut (.CLK, .SRST, .CMD_CODE, .WR_DATA, .WR_EN, .RD_EN, .RD_DATA,
    .RD_VALID, .CMD_ERR, .STRAP_LOAD, .STRAP_USER, .STRAP_ORDER, .ENABLE_REQ, .VOUT_ABOVE_PG,
    .BUS_EVT_VALID, .BUS_EVT_RAIL, .BUS_EVT_PG, .BUS_EVT_DOWN, .OUT_ON, .PG_O, .PG_OE,
    .MIN_DUTY, .EXTERNAL_TEMP_SENSE_EN, .RAIL_ID, .TUNE_EN, .TUNE_RESID, .TUNE_GAIN);
  rsc_peer_model u_peer (.clk(CLK), .send(send), .rail(rail), .down(down),
    .evt_valid(BUS_EVT_VALID), .evt_rail(BUS_EVT_RAIL), .evt_pg(BUS_EVT_PG),
    .evt_down(BUS_EVT_DOWN));
  // -------------------
  // tasks and functions
  // -------------------
  function [31:0] msk(input [7:0] a);
    msk = a == `RSC_OFF_TUNE ? 32'h01FF_FFFF : a == `RSC_OFF_PGD ? 32'h0000_FFFF :
      a == `RSC_OFF_ORDER ? 32'h0000_9F9F : 32'h0000_001F;
  endfunction
  function [7:0] duty(input [31:0] u);
    duty = u[2] ? {6'h00, u[4:3]} + 8'h01 : 8'h00;
  endfunction
  // clocks from vout high to power-ok: 20000 clocks a ms, negative exponents only
  function integer pgc(input [15:0] c);
    pgc = (c[10:0] * 20000) >> (32 - c[15:11]);
  endfunction
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge CLK) CMD_CODE <= a;
    WR_DATA <= v;
    WR_EN <= 1'b1;
    @(posedge CLK) WR_EN <= 1'b0;
    #1;
  endtask
  task rd(input [7:0] a);
    @(posedge CLK) CMD_CODE <= a;
    RD_EN <= 1'b1;
    @(posedge CLK) RD_EN <= 1'b0;
    #1 d = RD_DATA;
    f = {RD_VALID, CMD_ERR};
  endtask
  task chk_all;
    for (i = 0; i < 5; i = i + 1) begin
      rd(ofs[i]);
      chk("register", d, ex[i]);
    end
  endtask
  task strap(input [7:0] u, input [15:0] o);
    @(posedge CLK) STRAP_USER <= u;
    STRAP_ORDER <= o;
    STRAP_LOAD <= 1'b1;
    @(posedge CLK) STRAP_LOAD <= 1'b0;
  endtask
  task ev(input [4:0] r, input dn, input e);
    @(posedge CLK) rail <= r;
    down <= dn;
    send <= 1'b1;
    @(posedge CLK) send <= 1'b0;
    @(posedge CLK) #1 chk("out_on", {31'h0, OUT_ON}, {31'h0, e});
  endtask
  task complete_run;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------
  // clock and checks
  // ----------------
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end
  initial begin
    seed = 32'hdef0_9dbc;
    {n_fail, comparisons, cyc} = {32'h0, 32'h0, 32'h0};
    {WR_EN, RD_EN, STRAP_LOAD, ENABLE_REQ, VOUT_ABOVE_PG, send, down} = 7'h00;
    {CMD_CODE, WR_DATA, STRAP_USER, STRAP_ORDER, rail} = 69'h0;
    SRST = 1'b1;
    ofs[0] = `RSC_OFF_USER; ofs[1] = `RSC_OFF_RAIL; ofs[2] = `RSC_OFF_PGD;
    ofs[3] = `RSC_OFF_TUNE; ofs[4] = `RSC_OFF_ORDER;
    ex[0] = 32'h0; ex[1] = 32'h0; ex[2] = 32'h0000_CA00; ex[3] = 32'h015A_0100; ex[4] = 32'h0;
    repeat (4) @(posedge CLK);
    SRST <= 1'b0;
    chk_all;
    strap(8'h15, 16'h8182);
    ex[0] = 32'h15; ex[4] = 32'h8182;
    chk_all;
    wr(ofs[0], 32'h0); wr(ofs[4], 32'h0);
    strap(8'h1F, 16'h9F9F); // written values must outlast a later strap load
    ex[0] = 32'h0; ex[4] = 32'h0;
    chk_all;
    repeat (40) begin
      j = $unsigned($random(seed)) % 5;
      x = $random(seed);
      wr(ofs[j], x);
      ex[j] = x & msk(ofs[j]);
      rd(ofs[j]);
      chk("readback", d, ex[j]);
      chk("user", {8'h0, MIN_DUTY, EXTERNAL_TEMP_SENSE_EN, 10'h0, RAIL_ID},
        {8'h0, duty(ex[0]), ex[0][0], 10'h0, ex[1][4:0]});
      chk("tune", {7'h0, TUNE_EN, TUNE_RESID, TUNE_GAIN}, ex[3]);
    end
    wr(8'hD2, 32'hFFFF_FFFF);
    chk("wr_err", {31'h0, CMD_ERR}, 32'h1);
    rd(8'hD2);
    chk("rd_err", {30'h0, f}, 32'h1);
    chk_all;
    wr(ofs[4], 32'h8385);
    @(posedge CLK) ENABLE_REQ <= 1'b1;
    ev(5'd4, 1'b0, 1'b0); ev(5'd3, 1'b1, 1'b0); ev(5'd3, 1'b0, 1'b1);
    ev(5'd6, 1'b1, 1'b1); ev(5'd5, 1'b1, 1'b0);
    wr(ofs[4], 32'h0);
    repeat (3) @(posedge CLK);
    #1 chk("no_prequel", {31'h0, OUT_ON}, 32'h1);
    for (j = 0; j < 2; j = j + 1) begin
      wr(ofs[0], j * 2);
      x = j ? 32'h0000_F004 : 32'h0000_E808;
      wr(ofs[2], x);
      @(posedge CLK) VOUT_ABOVE_PG <= 1'b1;
      n = 0;
      while (PG_O !== 1'b1 && n < 22000) begin
        @(posedge CLK) #1;
        n = n + 1;
      end
      chk("pg_delay", n >= pgc(x) - 3 && n <= pgc(x) + 8, 32'h1);
      #1 chk("pg_drive_hi", {31'h0, PG_OE}, j);
      @(posedge CLK) VOUT_ABOVE_PG <= 1'b0;
      repeat (6) @(posedge CLK);
      #1 chk("pg_drive_lo", {30'h0, PG_O, PG_OE}, 32'h1);
    end
    complete_run;
  end
endmodule // rail_sequencing_config_tb
